// File: hdl/mdm_pkg.sv
// constants, codes and frame states of the motor driver monitor register bank
// Contract
// - current select register at 0Eh, read-write, 16 bits, FF00h after reset.
// - valid current codes are FF00h through FA05h; host picks the matching one.
// - apply command with an invalid current code flags an error and an alarm.
// - monitor words are read-only; writes to them change nothing.
// - monitor reads are served in setting and operation state alike.
// - reserved words 20h and 2Eh to 3Eh may read as anything.
// - status bit 5 main power, bit 4 overheat, bit 3 excitation.
// - status bit 2 pulse ready, bit 1 step zero, bit 0 alarm.
// - alarm word at 24h gives active alarm code in its low byte.
// - word at 26h gives board temperature in 0.1 degC counts.
// - word at 28h gives main supply voltage in 0.1 V counts.
// - word at 2Ah gives analog input voltage in 0.01 V counts.
// - pulse tally at 2Ch counts cw up, ccw down while operation possible.
// - pulse tally is signed 16 bits and wraps both ways.
// - pulse tally clears on the move from setting to operation state.
// - word at 40h gives motor phase kind in bit 0, one for two-phase.
// - word at 42h gives a fixed firmware kind identifier.
// - word at 44h gives firmware revision in 0.01 steps.
// - words travel high byte first, high byte at lower offset.
// - write frame is 02h, start address, two reserved bytes, then words.
package mdm_pkg;
    localparam logic [7:0]  ADDR_SELECT     = 8'h0E;
    localparam logic [7:0]  ADDR_STATUS     = 8'h22;
    localparam logic [7:0]  ADDR_ALARM      = 8'h24;
    localparam logic [7:0]  ADDR_TEMP       = 8'h26;
    localparam logic [7:0]  ADDR_SUPPLY     = 8'h28;
    localparam logic [7:0]  ADDR_ANALOG     = 8'h2A;
    localparam logic [7:0]  ADDR_TALLY      = 8'h2C;
    localparam logic [7:0]  ADDR_PHASE      = 8'h40;
    localparam logic [7:0]  ADDR_FW_KIND    = 8'h42;
    localparam logic [7:0]  ADDR_FW_REV     = 8'h44;
    localparam logic [7:0]  ADDR_STEP       = 8'h02;
    localparam logic [7:0]  CMD_WRITE       = 8'h02;
    localparam logic [7:0]  CMD_READ        = 8'h03;
    localparam logic [15:0] SELECT_RESET    = 16'hFF00;
    localparam logic [7:0]  SELECT_CODE_MAX = 8'h05;
    localparam logic [15:0] TALLY_RESET     = 16'h0000;
    localparam logic [15:0] TALLY_STEP      = 16'h0001;
    localparam logic [15:0] WORD_ZERO       = 16'h0000;
    localparam logic [7:0]  BYTE_ZERO       = 8'h00;
    localparam logic [2:0]  BIT_CNT_ZERO    = 3'h0;
    localparam logic [2:0]  BIT_CNT_ONE     = 3'h1;
    localparam int          STAT_POWER      = 5;
    localparam int          STAT_OVERHEAT   = 4;
    localparam int          STAT_EXCITE     = 3;
    localparam int          STAT_PULSE_INPUT_READY    = 2;
    localparam int          STAT_STEP_ZERO  = 1;
    localparam int          STAT_ALARM      = 0;
    localparam int          PHASE_BIT       = 0;
    // arbitrary identity values, not tied to any real firmware
    localparam logic [15:0] FW_KIND_DEFAULT = 16'h5A5A;
    localparam logic [15:0] FW_REV_DEFAULT  = 16'h0100;

    typedef enum logic [6:0] {
        FR_CMD   = 7'h01,
        FR_ADDR  = 7'h02,
        FR_RSV0  = 7'h04,
        FR_RSV1  = 7'h08,
        FR_HI    = 7'h10,
        FR_LO    = 7'h20,
        FR_SKIP  = 7'h40
    } mdm_frame_t;
endpackage

// File: hdl/mdm_regs.sv
// motor driver monitor register bank behind the spi port
`timescale 1ns/100ps
`default_nettype none
module mdm_regs #(
    parameter logic [15:0] FW_KIND_ID  = mdm_pkg::FW_KIND_DEFAULT,
    parameter logic [15:0] FW_REVISION = mdm_pkg::FW_REV_DEFAULT
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        spi_sclk,
    input  wire logic        spi_cs_n,
    input  wire logic        spi_mosi,
    output logic             spi_miso,
    output logic             spi_miso_oe,
    input  wire logic        main_power_present,
    input  wire logic        overheat,
    input  wire logic        excitation_active,
    input  wire logic        pulse_input_ready,
    input  wire logic        step_zero_position,
    input  wire logic        alarm_present,
    input  wire logic [7:0]  alarm_code_field,
    input  wire logic [15:0] board_temperature,
    input  wire logic [15:0] supply_voltage_level,
    input  wire logic [15:0] analog_input_level,
    input  wire logic        motor_two_phase,
    input  wire logic        operation_state,
    input  wire logic        operation_possible,
    input  wire logic        cw_pulse,
    input  wire logic        ccw_pulse,
    input  wire logic        apply_settings,
    output logic [15:0]      motor_current_select,
    output logic             apply_error,
    output logic             alarm_raise
);
    mdm_pkg::mdm_frame_t state_reg;
    logic [7:0]          cmd_reg;
    logic [7:0]          addr_reg;
    logic [7:0]          wr_hi_reg;
    logic [7:0]          tx_reg;
    logic [15:0]         snap_reg;
    logic [15:0]         select_reg;
    logic [15:0]         tally_reg;
    logic [15:0]         tally_next;
    logic                op_prev_reg;
    logic                err_reg;
    logic                alarm_reg;
    logic                frame_start;
    logic                rx_valid;
    logic [7:0]          rx_byte;
    logic                is_write;
    logic                is_read;
    logic                select_valid;
    logic                enter_operation;
    logic                select_we;
    logic [15:0]         word_now;
    logic [15:0]         word_next;

    mdm_spi_shift u_shift (
        .clk         (clk),
        .rst         (rst),
        .spi_sclk    (spi_sclk),
        .spi_cs_n    (spi_cs_n),
        .spi_mosi    (spi_mosi),
        .spi_miso    (spi_miso),
        .spi_miso_oe (spi_miso_oe),
        .tx_byte     (tx_reg),
        .frame_start (frame_start),
        .rx_valid    (rx_valid),
        .rx_byte     (rx_byte)
    );

    function automatic logic code_ok(input logic [15:0] code);
        code_ok = (code[15:8] == ~code[7:0])
                  && (code[7:0] <= mdm_pkg::SELECT_CODE_MAX);
    endfunction

    // whole word sampled in one cycle so both bytes belong together
    function automatic logic [15:0] read_word(input logic [7:0] addr);
        logic [15:0] w;
        w = mdm_pkg::WORD_ZERO;
        case (addr)
            mdm_pkg::ADDR_SELECT: w = select_reg;
            mdm_pkg::ADDR_STATUS: begin
                w[mdm_pkg::STAT_POWER]     = main_power_present;
                w[mdm_pkg::STAT_OVERHEAT]  = overheat;
                w[mdm_pkg::STAT_EXCITE]    = excitation_active;
                w[mdm_pkg::STAT_PULSE_INPUT_READY]   = pulse_input_ready;
                w[mdm_pkg::STAT_STEP_ZERO] = step_zero_position;
                w[mdm_pkg::STAT_ALARM]     = alarm_present;
            end
            mdm_pkg::ADDR_ALARM: begin
                // code masked off without an alarm
                if (alarm_present) begin
                    w[7:0] = alarm_code_field;
                end
            end
            mdm_pkg::ADDR_TEMP:    w = board_temperature;
            mdm_pkg::ADDR_SUPPLY:  w = supply_voltage_level;
            mdm_pkg::ADDR_ANALOG:  w = analog_input_level;
            mdm_pkg::ADDR_TALLY:   w = tally_reg;
            mdm_pkg::ADDR_PHASE:   w[mdm_pkg::PHASE_BIT] = motor_two_phase;
            mdm_pkg::ADDR_FW_KIND: w = FW_KIND_ID;
            mdm_pkg::ADDR_FW_REV:  w = FW_REVISION;
            // reserved and unmapped words read zero
            default: w = mdm_pkg::WORD_ZERO;
        endcase
        read_word = w;
    endfunction

    assign is_write        = (cmd_reg == mdm_pkg::CMD_WRITE);
    assign is_read         = (cmd_reg == mdm_pkg::CMD_READ);
    assign select_valid    = code_ok(select_reg);
    assign enter_operation = operation_state & ~op_prev_reg;
    // only the select word is writable
    assign select_we       = rx_valid && (state_reg == mdm_pkg::FR_LO)
                             && is_write
                             && (addr_reg == mdm_pkg::ADDR_SELECT);
    assign word_now        = read_word(addr_reg);
    assign word_next       = read_word(addr_reg + mdm_pkg::ADDR_STEP);
    assign motor_current_select = select_reg;
    assign apply_error     = err_reg;
    assign alarm_raise     = alarm_reg;

    // frame sequencer; reads run regardless of operation_state
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= mdm_pkg::FR_CMD;
            cmd_reg   <= mdm_pkg::BYTE_ZERO;
            addr_reg  <= mdm_pkg::BYTE_ZERO;
            wr_hi_reg <= mdm_pkg::BYTE_ZERO;
        end else if (frame_start) begin
            state_reg <= mdm_pkg::FR_CMD;
        end else if (rx_valid) begin
            case (state_reg)
                mdm_pkg::FR_CMD: begin
                    cmd_reg <= rx_byte;
                    if (rx_byte == mdm_pkg::CMD_WRITE
                        || rx_byte == mdm_pkg::CMD_READ) begin
                        state_reg <= mdm_pkg::FR_ADDR;
                    end else begin
                        state_reg <= mdm_pkg::FR_SKIP;
                    end
                end
                mdm_pkg::FR_ADDR: begin
                    addr_reg  <= rx_byte;
                    state_reg <= mdm_pkg::FR_RSV0;
                end
                mdm_pkg::FR_RSV0: state_reg <= mdm_pkg::FR_RSV1;
                mdm_pkg::FR_RSV1: state_reg <= mdm_pkg::FR_HI;
                mdm_pkg::FR_HI: begin
                    wr_hi_reg <= rx_byte;
                    state_reg <= mdm_pkg::FR_LO;
                end
                mdm_pkg::FR_LO: begin
                    addr_reg  <= addr_reg + mdm_pkg::ADDR_STEP;
                    state_reg <= mdm_pkg::FR_HI;
                end
                mdm_pkg::FR_SKIP: state_reg <= mdm_pkg::FR_SKIP;
                default: state_reg <= mdm_pkg::FR_SKIP;
            endcase
        end
    end

    // outgoing bytes, high byte first from a single snapshot
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_reg   <= mdm_pkg::BYTE_ZERO;
            snap_reg <= mdm_pkg::WORD_ZERO;
        end else if (frame_start) begin
            tx_reg <= mdm_pkg::BYTE_ZERO;
        end else if (rx_valid) begin
            tx_reg <= mdm_pkg::BYTE_ZERO;
            if (is_read && state_reg == mdm_pkg::FR_RSV1) begin
                snap_reg <= word_now;
                tx_reg   <= word_now[15:8];
            end else if (is_read && state_reg == mdm_pkg::FR_HI) begin
                tx_reg <= snap_reg[7:0];
            end else if (is_read && state_reg == mdm_pkg::FR_LO) begin
                snap_reg <= word_next;
                tx_reg   <= word_next[15:8];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            select_reg <= mdm_pkg::SELECT_RESET;
        end else if (select_we) begin
            select_reg <= {wr_hi_reg, rx_byte};
        end
    end

    // invalid code is only caught when apply runs, not when written
    always_ff @(posedge clk) begin
        if (rst) begin
            err_reg   <= 1'b0;
            alarm_reg <= 1'b0;
        end else begin
            err_reg   <= apply_settings & ~select_valid;
            alarm_reg <= apply_settings & ~select_valid;
        end
    end

    // simultaneous cw and ccw cancel out
    always_comb begin
        tally_next = tally_reg;
        if (enter_operation) begin
            tally_next = mdm_pkg::TALLY_RESET;
        end else if (operation_possible && cw_pulse && !ccw_pulse) begin
            tally_next = tally_reg + mdm_pkg::TALLY_STEP;
        end else if (operation_possible && ccw_pulse && !cw_pulse) begin
            tally_next = tally_reg - mdm_pkg::TALLY_STEP;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tally_reg   <= mdm_pkg::TALLY_RESET;
            op_prev_reg <= 1'b0;
        end else begin
            tally_reg   <= tally_next;
            op_prev_reg <= operation_state;
        end
    end

    a_select_reset: assert property (
        @(posedge clk) $fell(rst) |-> select_reg == mdm_pkg::SELECT_RESET)
        else $error("select register not at reset value");

    a_select_write: assert property (
        @(posedge clk) disable iff (rst)
        select_we |=> select_reg == {$past(wr_hi_reg), $past(rx_byte)})
        else $error("select write lost");

    a_monitor_readonly: assert property (
        @(posedge clk) disable iff (rst)
        (rx_valid && state_reg == mdm_pkg::FR_LO && is_write
         && addr_reg != mdm_pkg::ADDR_SELECT) |=> $stable(select_reg))
        else $error("write to monitor word changed state");

    a_apply_reject: assert property (
        @(posedge clk) disable iff (rst)
        apply_settings && !select_valid |=> apply_error && alarm_raise)
        else $error("invalid code not flagged");

    a_apply_accept: assert property (
        @(posedge clk) disable iff (rst)
        !apply_settings |=> !apply_error && !alarm_raise)
        else $error("spurious apply error");

    a_tally_clear: assert property (
        @(posedge clk) disable iff (rst)
        operation_state && !op_prev_reg |=> tally_reg == mdm_pkg::TALLY_RESET)
        else $error("tally not cleared on entry to operation");

    a_tally_up: assert property (
        @(posedge clk) disable iff (rst)
        !enter_operation && operation_possible && cw_pulse && !ccw_pulse
        |=> tally_reg == 16'($past(tally_reg) + mdm_pkg::TALLY_STEP))
        else $error("tally did not count up");

    a_tally_down: assert property (
        @(posedge clk) disable iff (rst)
        !enter_operation && operation_possible && ccw_pulse && !cw_pulse
        |=> tally_reg == 16'($past(tally_reg) - mdm_pkg::TALLY_STEP))
        else $error("tally did not count down");

    a_tally_hold: assert property (
        @(posedge clk) disable iff (rst)
        !enter_operation && !operation_possible |=> $stable(tally_reg))
        else $error("tally moved while operation impossible");

    sequence s_read_hi;
        rx_valid && is_read && state_reg == mdm_pkg::FR_HI;
    endsequence

    a_snap_pair: assert property (
        @(posedge clk) disable iff (rst)
        s_read_hi ##0 !frame_start |=> tx_reg == $past(snap_reg[7:0]))
        else $error("low byte not from snapshot");

    a_alarm_masked: assert property (
        @(posedge clk) disable iff (rst)
        !alarm_present |-> read_word(mdm_pkg::ADDR_ALARM) == mdm_pkg::WORD_ZERO)
        else $error("alarm code shown without alarm");
endmodule
`default_nettype wire

// File: hdl/mdm_spi_shift.sv
// spi mode 0 byte shifter with pin synchronisers
`timescale 1ns/100ps
`default_nettype none
module mdm_spi_shift (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       spi_sclk,
    input  wire logic       spi_cs_n,
    input  wire logic       spi_mosi,
    output logic            spi_miso,
    output logic            spi_miso_oe,
    input  wire logic [7:0] tx_byte,
    output logic            frame_start,
    output logic            rx_valid,
    output logic [7:0]      rx_byte
);
    logic [2:0] sclk_sync_reg;
    logic [2:0] cs_sync_reg;
    logic [1:0] mosi_sync_reg;
    logic [2:0] bit_cnt_reg;
    logic [7:0] rx_shift_reg;
    logic [7:0] tx_shift_reg;
    logic       rise;
    logic       fall;
    logic       active;

    // stage 0 feeds only stage 1; edges are taken from stages 1 and 2
    always_ff @(posedge clk) begin
        if (rst) begin
            sclk_sync_reg <= 3'h0;
            cs_sync_reg   <= 3'h7;
            mosi_sync_reg <= 2'h0;
        end else begin
            sclk_sync_reg <= {sclk_sync_reg[1:0], spi_sclk};
            cs_sync_reg   <= {cs_sync_reg[1:0], spi_cs_n};
            mosi_sync_reg <= {mosi_sync_reg[0], spi_mosi};
        end
    end

    assign active      = ~cs_sync_reg[1];
    assign rise        = active & sclk_sync_reg[1] & ~sclk_sync_reg[2];
    assign fall        = active & ~sclk_sync_reg[1] & sclk_sync_reg[2];
    assign frame_start = cs_sync_reg[2] & ~cs_sync_reg[1];
    assign spi_miso    = tx_shift_reg[7];
    assign spi_miso_oe = active;
    assign rx_byte     = rx_shift_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            bit_cnt_reg  <= mdm_pkg::BIT_CNT_ZERO;
            rx_shift_reg <= mdm_pkg::BYTE_ZERO;
            rx_valid     <= 1'b0;
        end else begin
            rx_valid <= 1'b0;
            if (frame_start) begin
                bit_cnt_reg <= mdm_pkg::BIT_CNT_ZERO;
            end else if (rise) begin
                rx_shift_reg <= {rx_shift_reg[6:0], mosi_sync_reg[1]};
                bit_cnt_reg  <= bit_cnt_reg + mdm_pkg::BIT_CNT_ONE;
                rx_valid     <= (bit_cnt_reg == 3'h7);
            end
        end
    end

    // next byte is loaded on the falling edge that starts it
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_shift_reg <= mdm_pkg::BYTE_ZERO;
        // command byte slot always answers zero; tx_byte may be stale here
        end else if (frame_start) begin
            tx_shift_reg <= mdm_pkg::BYTE_ZERO;
        end else if (fall) begin
            if (bit_cnt_reg == mdm_pkg::BIT_CNT_ZERO) begin
                tx_shift_reg <= tx_byte;
            end else begin
                tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
            end
        end
    end
endmodule
`default_nettype wire

// File: verification/mdm_host_model.sv
// spi host model that issues register frames to the monitor bank
`timescale 1ns/100ps
`default_nettype none
module mdm_host_model (
    input  wire logic clk,
    output logic      spi_sclk,
    output logic      spi_cs_n,
    output logic      spi_mosi,
    input  wire logic spi_miso,
    input  wire logic spi_miso_oe
);
    // half period well above the synchroniser delay of the device
    localparam int HALF = 8;
    logic miso_seen;

    // released line reads back inverted, so stale data never passes
    assign miso_seen = spi_miso_oe ? spi_miso : ~spi_miso;

    initial begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end

    task automatic byte_xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int k = 7; k >= 0; k--) begin
            spi_mosi = tx[k];
            repeat (HALF) @(posedge clk);
            #1 rx[k] = miso_seen;
            spi_sclk = 1'b1;
            repeat (HALF) @(posedge clk);
            #1 spi_sclk = 1'b0;
        end
    endtask

    // callers address only mapped words, never reserved gaps
    task automatic frame(input logic [7:0] cmd, input logic [7:0] addr,
                         input int n, input logic [15:0] wd [8],
                         output logic [15:0] rd [8]);
        logic [7:0] tx;
        logic [7:0] rx;
        int         w;
        @(posedge clk);
        #1 spi_cs_n = 1'b0;
        repeat (HALF) @(posedge clk);
        #1;
        for (int i = 0; i < 4 + 2 * n; i++) begin
            w = (i - 4) / 2;
            if (i < 2)
                tx = i == 0 ? cmd : addr;
            else if (i < 4)
                tx = 8'h00;
            else
                tx = i[0] ? wd[w][7:0] : wd[w][15:8];
            byte_xfer(tx, rx);
            if (i >= 4 && i[0]) rd[w][7:0] = rx;
            else if (i >= 4) rd[w][15:8] = rx;
        end
        repeat (HALF) @(posedge clk);
        #1 spi_cs_n = 1'b1;
        spi_mosi = ~spi_mosi;
        repeat (HALF) @(posedge clk);
        // callers drive inputs right after return, so step off the edge
        #1;
    endtask
endmodule
`default_nettype wire

// File: verification/tb_top.sv
// self-checking bench for the monitor register bank
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic        clk, rst, spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
    logic        two_phase, op_state, op_poss, cw, ccw, apply;
    logic        apply_error, alarm_raise;
    logic [5:0]  stat;
    logic [7:0]  code;
    logic [15:0] temp, supply, analog, sel;
    logic [15:0] wd [8];
    logic [15:0] rd [8];
    int          failures = 0;
    int          checks = 0;

    mdm_host_model host (.clk(clk), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe));
    mdm_regs dut (.clk(clk), .rst(rst), .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
        .spi_miso_oe(spi_miso_oe), .main_power_present(stat[5]),
        .overheat(stat[4]), .excitation_active(stat[3]),
        .pulse_input_ready(stat[2]), .step_zero_position(stat[1]),
        .alarm_present(stat[0]), .alarm_code_field(code),
        .board_temperature(temp), .supply_voltage_level(supply),
        .analog_input_level(analog), .motor_two_phase(two_phase),
        .operation_state(op_state), .operation_possible(op_poss),
        .cw_pulse(cw), .ccw_pulse(ccw), .apply_settings(apply),
        .motor_current_select(sel), .apply_error(apply_error),
        .alarm_raise(alarm_raise));

    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task finish_test;
        if (failures == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        wd[0] = v;
        host.frame(mdm_pkg::CMD_WRITE, a, 1, wd, rd);
    endtask

    task automatic rd_n(input logic [7:0] a, input int n);
        host.frame(mdm_pkg::CMD_READ, a, n, wd, rd);
    endtask

    // both outputs must pulse together, exactly once, or not at all
    task automatic apply_chk(input logic [15:0] v, input logic bad);
        int hits;
        hits = 0;
        wr(mdm_pkg::ADDR_SELECT, v);
        chk("select", v, sel);
        @(posedge clk);
        #1 apply = 1'b1;
        @(posedge clk);
        #1 apply = 1'b0;
        repeat (4) begin
            if (apply_error === 1'b1) hits++;
            if (alarm_raise !== apply_error) hits += 8;
            @(posedge clk);
            #1;
        end
        chk("apply pulses", bad ? 16'h0001 : 16'h0000, 16'(hits));
    endtask

    task automatic pulses(input logic up, input int n);
        cw = up;
        ccw = ~up;
        repeat (n) @(posedge clk);
        #1 cw = 1'b0;
        ccw = 1'b0;
        rd_n(mdm_pkg::ADDR_TALLY, 1);
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        repeat (100000) @(posedge clk);
        failures++;
        $display("[FAIL] watchdog expected done seen hang");
        finish_test();
    end

    initial begin
        rst = 1'b1;
        {two_phase, op_state, op_poss, cw, ccw, apply} = 6'h00;
        stat = 6'h00;
        code = 8'h5C;
        temp = 16'h01F4;
        supply = 16'h00F0;
        analog = 16'h00FA;
        repeat (20) @(posedge clk);
        #1 rst = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        chk("select reset", mdm_pkg::SELECT_RESET, sel);
        rd_n(mdm_pkg::ADDR_SELECT, 1);
        chk("select read", mdm_pkg::SELECT_RESET, rd[0]);
        for (int c = 0; c < 6; c++)
            apply_chk({8'hFF - 8'(c), 8'(c)}, 1'b0);
        apply_chk(16'hF906, 1'b1);
        apply_chk(16'hFF01, 1'b1);
        wr(mdm_pkg::ADDR_TEMP, 16'h1234);
        chk("select after monitor write", 16'hFF01, sel);
        for (int b = 0; b < 6; b++) begin
            stat = 6'(1 << b);
            rd_n(mdm_pkg::ADDR_STATUS, 6);
            chk("status", 16'(1 << b), rd[0]);
            // upper byte is don't-care for the host
            chk("alarm code", stat[0] ? 16'h005C : 16'h0000,
                {8'h00, rd[1][7:0]});
            chk("temperature", temp, rd[2]);
            chk("supply", supply, rd[3]);
            chk("analog", analog, rd[4]);
            chk("tally reset", mdm_pkg::TALLY_RESET, rd[5]);
        end
        op_state = 1'b1;
        op_poss = 1'b1;
        // entry into operation clears the tally and would eat a first pulse
        @(posedge clk);
        #1;
        pulses(1'b1, 32767);
        chk("tally up", 16'h7FFF, rd[0]);
        pulses(1'b1, 1);
        chk("tally wrap up", 16'h8000, rd[0]);
        pulses(1'b0, 1);
        chk("tally wrap down", 16'h7FFF, rd[0]);
        op_poss = 1'b0;
        op_state = 1'b0;
        pulses(1'b0, 3);
        chk("tally gated", 16'h7FFF, rd[0]);
        op_state = 1'b1;
        rd_n(mdm_pkg::ADDR_TALLY, 1);
        chk("tally cleared", 16'h0000, rd[0]);
        two_phase = 1'b1;
        rd_n(mdm_pkg::ADDR_PHASE, 3);
        chk("phase two", 16'h0001, {15'h0, rd[0][0]});
        chk("fw kind", mdm_pkg::FW_KIND_DEFAULT, rd[1]);
        chk("fw revision", mdm_pkg::FW_REV_DEFAULT, rd[2]);
        two_phase = 1'b0;
        rd_n(mdm_pkg::ADDR_PHASE, 1);
        chk("phase five", 16'h0000, {15'h0, rd[0][0]});
        finish_test();
    end
endmodule
`default_nettype wire
